// ===== logic/scwp_pkg.sv
// Package for the serial control word port: widths, field layout, timing figures
package scwp_pkg;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned CNT_W       = 5;
  localparam int unsigned CTRL_W      = 4;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned CTRL_MSB    = 15;
  localparam int unsigned CTRL_LSB    = 12;
  localparam int unsigned ADDR_MSB    = 11;
  localparam int unsigned ADDR_LSB    = 8;
  localparam int unsigned DATA_MSB    = 7;
  localparam int unsigned DATA_LSB    = 0;
  localparam int unsigned SYNC_STAGES = 2;
  // Link limits, in their own units
  localparam int unsigned SCLK_MAX_MHZ = 40;
  localparam int unsigned MCLK_MHZ     = 125;
  localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ZERO      = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE       = 5'h01;
  localparam logic [WORD_W-1:0] WORD_ZERO    = 16'h0000;
  // Levels of {serial clock, frame strobe, data} that the synchronisers reset to
  localparam logic [2:0]        LINK_IDLE    = 3'h6;
  typedef enum logic [1:0] {SCWP_IDLE, SCWP_SHIFT, SCWP_FULL} scwp_state_e;
endpackage

// ===== logic/scwp_sync_if.sv
// Interface carrying the synchronised link levels to the frame logic
`timescale 1ns/1ps
`default_nettype none
interface scwp_sync_if;
  logic sclk_s;
  logic frame_n_s;
  logic data_s;
  modport src (output sclk_s, output frame_n_s, output data_s);
  modport dst (input sclk_s, input frame_n_s, input data_s);
endinterface
`default_nettype wire

// ===== logic/scwp_sync.sv
// Two-flop synchronisers for the serial link pins
`timescale 1ns/1ps
`default_nettype none
module scwp_sync
  import scwp_pkg::*;
(
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   arst_n,
  // Raw pins
  input  wire logic   serial_clk,
  input  wire logic   frame_strobe_n,
  input  wire logic   serial_data_in,
  // Synchronised levels
  scwp_sync_if.src    sync
);
  logic [2:0] meta_r;
  logic [2:0] stab_r;
  logic [2:0] meta_nxt;
  logic [2:0] stab_nxt;

  always_comb begin
    meta_nxt = {serial_clk, frame_strobe_n, serial_data_in};
    stab_nxt = meta_r;
  end

  // Frame strobe resets high so no frame is seen out of reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= LINK_IDLE;
      stab_r <= LINK_IDLE;
    end else begin
      meta_r <= meta_nxt;
      stab_r <= stab_nxt;
    end
  end

  assign sync.sclk_s    = stab_r[2];
  assign sync.frame_n_s = stab_r[1];
  assign sync.data_s    = stab_r[0];
endmodule
`default_nettype wire

// ===== logic/scwp_port.sv
// Serial control word port: frame, shift and commit of 16-bit words
//
// What this block does
// - A serial clock that runs freely or rests high or low between writes is accepted.
// - One low period of the frame strobe carries exactly one 16-bit word.
// - Each data bit is sampled on a falling serial clock edge.
// - Words travel most significant bit first; LSB-first hosts reorder before sending.
// - A word splits into four control bits, four address bits and eight data bits.
`timescale 1ns/1ps
`default_nettype none
module scwp_port (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  // Serial link pins
  input  wire logic                   serial_clk,
  input  wire logic                   frame_strobe_n,
  input  wire logic                   serial_data_in,
  // Committed word
  output logic                        word_valid,
  output logic [scwp_pkg::WORD_W-1:0] word_out,
  output logic [scwp_pkg::CTRL_W-1:0] word_ctrl,
  output logic [scwp_pkg::ADDR_W-1:0] word_addr,
  output logic [scwp_pkg::DATA_W-1:0] word_data,
  // Status
  output logic                        frame_active,
  output logic                        frame_error
);
  import scwp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  scwp_sync_if sync ();

  scwp_sync u_sync (
    .mclk           (mclk),
    .arst_n         (arst_n),
    .serial_clk     (serial_clk),
    .frame_strobe_n (frame_strobe_n),
    .serial_data_in (serial_data_in),
    .sync           (sync)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Edges are found only on the second-stage levels; 125 MHz sampling
  // of a 40 MHz link leaves at least one sample per half period.
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic sclk_fall;

  always_comb begin
    sclk_d_nxt = sync.sclk_s;
  end

  // Reset level equals the synchroniser's, so no edge is made up before the pins are sampled
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d_r <= LINK_IDLE[2];
    end else begin
      sclk_d_r <= sclk_d_nxt;
    end
  end

  // Only falling edges count, so a clock idling either level or running freely is harmless
  assign sclk_fall = sclk_d_r & ~sync.sclk_s;

  // ----------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------
  logic frame_d_r;
  logic frame_d_nxt;
  logic frame_rise;

  always_comb begin
    frame_d_nxt = sync.frame_n_s;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      frame_d_r <= LINK_IDLE[1];
    end else begin
      frame_d_r <= frame_d_nxt;
    end
  end

  // Strobe rise closes the frame and times the short-frame error pulse
  assign frame_rise = ~frame_d_r & sync.frame_n_s;

  // ----------------------------------------------------------------
  // Frame and shift state
  // ----------------------------------------------------------------
  scwp_state_e       state_r;
  scwp_state_e       state_nxt;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic              commit;
  logic              short_frame;

  always_comb begin
    state_nxt   = state_r;
    shift_nxt   = shift_r;
    cnt_nxt     = cnt_r;
    commit      = 1'b0;
    short_frame = 1'b0;
    case (state_r)
      SCWP_IDLE: begin
        cnt_nxt = CNT_ZERO;
        if (!sync.frame_n_s) begin
          state_nxt = SCWP_SHIFT;
        end
      end
      SCWP_SHIFT: begin
        if (sync.frame_n_s) begin
          // Strobe rose early: the partial word is thrown away
          short_frame = (cnt_r != CNT_ZERO);
          state_nxt   = SCWP_IDLE;
        end else if (sclk_fall) begin
          shift_nxt = {shift_r[WORD_W-2:0], sync.data_s};
          cnt_nxt   = cnt_r + CNT_ONE;
          if (cnt_nxt == BITS_PER_WORD) begin
            commit    = 1'b1;
            state_nxt = SCWP_FULL;
          end
        end
      end
      SCWP_FULL: begin
        // Further edges in the same low period are ignored: one word per frame
        if (sync.frame_n_s) begin
          state_nxt = SCWP_IDLE;
        end
      end
      default: begin
        state_nxt = SCWP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SCWP_IDLE;
      shift_r <= WORD_ZERO;
      cnt_r   <= CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic              valid_r;
  logic              valid_nxt;
  logic [WORD_W-1:0] word_r;
  logic [WORD_W-1:0] word_nxt;
  logic              err_r;
  logic              err_nxt;

  always_comb begin
    valid_nxt = commit;
    word_nxt  = commit ? shift_nxt : word_r;
    // Error pulse marks a dropped short frame
    // A strobe pulse with no bits loses nothing and stays silent
    err_nxt   = short_frame & frame_rise;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      valid_r <= 1'b0;
      word_r  <= WORD_ZERO;
      err_r   <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      word_r  <= word_nxt;
      err_r   <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  // Taken from the next state so the flag is a flop yet keeps the state's timing
  logic active_r;
  logic active_nxt;

  always_comb begin
    active_nxt = (state_nxt != SCWP_IDLE);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      active_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
    end
  end

  assign word_valid   = valid_r;
  assign word_out     = word_r;
  assign word_ctrl    = word_r[CTRL_MSB:CTRL_LSB];
  assign word_addr    = word_r[ADDR_MSB:ADDR_LSB];
  assign word_data    = word_r[DATA_MSB:DATA_LSB];
  assign frame_active = active_r;
  assign frame_error  = err_r;
endmodule
`default_nettype wire

// ===== test/scwp_monitor.sv
// Checker on the serial control word port pins
`timescale 1ns/1ps
`default_nettype none
module scwp_monitor
  import scwp_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              arst_n,
  // Link pins
  input wire logic              serial_clk,
  input wire logic              frame_strobe_n,
  input wire logic              serial_data_in,
  // Word and status
  input wire logic              word_valid,
  input wire logic [WORD_W-1:0] word_out,
  input wire logic [CTRL_W-1:0] word_ctrl,
  input wire logic [ADDR_W-1:0] word_addr,
  input wire logic [DATA_W-1:0] word_data,
  input wire logic              frame_active,
  input wire logic              frame_error
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  field_split_a: assert property (word_out == {word_ctrl, word_addr, word_data})
    else $error("fields differ from word");
  commit_only_a: assert property ($changed(word_out) |-> word_valid)
    else $error("word changed without commit");
  valid_pulse_a: assert property (word_valid |=> !word_valid [*8])
    else $error("second commit too soon");
  error_pulse_a: assert property (frame_error |=> !frame_error)
    else $error("error pulse too long");
  commit_in_frame_a: assert property (word_valid |-> frame_active && $past(frame_active))
    else $error("commit outside a frame");
  one_outcome_a: assert property (!(word_valid && frame_error))
    else $error("commit and error together");
  frame_start_a: assert property ($rose(frame_active) |-> !$past(frame_strobe_n, 2))
    else $error("frame began without strobe");
  frame_end_a: assert property (frame_strobe_n [*8] |-> !frame_active)
    else $error("frame outlived strobe");
endmodule
`default_nettype wire

// ===== test/scwp_host.sv
// Host model driving the three link pins
`timescale 1ns/1ps
`default_nettype none
module scwp_host (
  // Pacing clock
  input  wire logic mclk,
  // Link pins
  output var logic  serial_clk,
  output var logic  frame_strobe_n,
  output var logic  serial_data_in
);
  // Four mclk periods per half bit: a 64 ns serial clock, well under 40 MHz
  localparam int HALF = 4;

  initial begin
    serial_clk     = 1'b1;
    frame_strobe_n = 1'b1; // Strobe is modelled active low, as after any inversion
    serial_data_in = 1'b0;
  end

  // Pins move only on mclk edges; this serial clock is apart from any synthesis clock
  task automatic wait_half(input int n);
    repeat (n * HALF) @(posedge mclk);
  endtask

  task automatic send(input logic [15:0] word, input int nbits, input bit split, input bit rest);
    @(posedge mclk);
    serial_clk <= rest;
    wait_half(2);
    frame_strobe_n <= 1'b0;
    wait_half(2);
    for (int i = 0; i < nbits; i++) begin
      if (split && i == 8) begin
        serial_clk <= 1'b1;
        wait_half(4);
      end
      serial_clk     <= 1'b1;
      serial_data_in <= (i < 16) ? word[15-i] : ~serial_data_in;
      wait_half(1);
      serial_clk <= 1'b0;
      wait_half(1);
    end
    serial_clk <= rest;
    wait_half(1);
    frame_strobe_n <= 1'b1;
    serial_data_in <= ~serial_data_in;
    wait_half(2);
  endtask

  // Free-running clock while the strobe stays high
  task automatic run_clock(input int periods);
    for (int i = 0; i < periods; i++) begin
      serial_clk <= 1'b0;
      wait_half(1);
      serial_clk <= 1'b1;
      wait_half(1);
    end
  endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Testbench for the serial control word port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scwp_pkg::*;
  logic              mclk = 1'b0;
  logic              arst_n = 1'b0;
  wire logic         s_clk, s_frm_n, s_dat;
  logic              word_valid, frame_active, frame_error;
  logic [WORD_W-1:0] word_out;
  logic [CTRL_W-1:0] word_ctrl;
  logic [ADDR_W-1:0] word_addr;
  logic [DATA_W-1:0] word_data;
  int                miscompares = 0;
  int                cmp_count = 0;
  int                n_v = 0;
  int                n_e = 0;
  always #4 mclk = ~mclk;
  scwp_host host (.mclk(mclk), .serial_clk(s_clk), .frame_strobe_n(s_frm_n), .serial_data_in(s_dat));
  scwp_port i_scwp_port (.mclk(mclk), .arst_n(arst_n), .serial_clk(s_clk), .frame_strobe_n(s_frm_n),
    .serial_data_in(s_dat), .word_valid(word_valid), .word_out(word_out), .word_ctrl(word_ctrl),
    .word_addr(word_addr), .word_data(word_data), .frame_active(frame_active), .frame_error(frame_error));
  always @(posedge mclk) begin
    if (word_valid === 1'b1) n_v <= n_v + 1;
    if (frame_error === 1'b1) n_e <= n_e + 1;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One frame, optionally cut by a reset pulse ra cycles in; then commits, errors, word and activity
  task automatic frame(input string nm, input logic [15:0] w, input int nb, input bit sp, input bit rs,
                       input int ra, input int ev, input int ee, input logic [15:0] ew);
    int v0;
    int e0;
    v0 = n_v;
    e0 = n_e;
    fork
      host.send(w, nb, sp, rs);
      begin
        repeat (24) @(posedge mclk);
        check("frame_active in frame", 16'h0001, {15'h0000, frame_active});
      end
      begin
        if (ra > 0) begin
          repeat (ra) @(posedge mclk);
          arst_n <= 1'b0;
          repeat (2) @(posedge mclk);
          arst_n <= 1'b1;
        end
      end
    join
    repeat (8) @(posedge mclk);
    check("commits", 16'(ev), 16'(n_v - v0));
    check("errors", 16'(ee), 16'(n_e - e0));
    check("word_out", ew, word_out);
    check("frame_active after", 16'h0000, {15'h0000, frame_active});
    $display("test %s done", nm);
  endtask
  task automatic t_reset();
    check("reset word", 16'h0000, word_out);
    check("reset valid", 16'h0000, {15'h0000, word_valid});
    check("reset error", 16'h0000, {15'h0000, frame_error});
    check("reset active", 16'h0000, {15'h0000, frame_active});
    $display("test reset done");
  endtask
  task automatic t_msb();
    frame("msb", 16'hA5C3, 16, 1'b0, 1'b1, 0, 1, 0, 16'hA5C3);
    check("ctrl", 16'h000A, {12'h000, word_ctrl});
    check("addr", 16'h0005, {12'h000, word_addr});
    check("data", 16'h00C3, {8'h00, word_data});
  endtask
  task automatic t_rest_low();
    frame("rest low", 16'h3C96, 16, 1'b0, 1'b0, 0, 1, 0, 16'h3C96);
  endtask
  task automatic t_bytes();
    frame("bytes", 16'h5A0F, 16, 1'b1, 1'b1, 0, 1, 0, 16'h5A0F);
  endtask
  task automatic t_short();
    frame("short", 16'hFFFF, 9, 1'b0, 1'b1, 0, 0, 1, 16'h5A0F);
  endtask
  task automatic t_extra();
    frame("extra", 16'h1234, 20, 1'b0, 1'b0, 0, 1, 0, 16'h1234);
  endtask
  task automatic t_free();
    int v0;
    v0 = n_v;
    host.run_clock(6);
    repeat (8) @(posedge mclk);
    check("idle commits", 16'h0000, 16'(n_v - v0));
    check("idle active", 16'h0000, {15'h0000, frame_active});
    frame("free clock", 16'h96E1, 16, 1'b0, 1'b1, 0, 1, 0, 16'h96E1);
  endtask
  // Reset in mid-frame: the rest of the bits make a short frame, and nothing is committed
  task automatic t_cut();
    frame("cut by reset", 16'hC3A5, 16, 1'b0, 1'b1, 58, 0, 1, 16'h0000);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_msb();
    t_rest_low();
    t_bytes();
    t_short();
    t_extra();
    t_free();
    t_cut();
    end_sim();
  end
  // Seven frames and the idle clock take about 10 us
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end
endmodule
bind scwp_port scwp_monitor i_scwp_monitor (.mclk(mclk), .arst_n(arst_n), .serial_clk(serial_clk),
  .frame_strobe_n(frame_strobe_n), .serial_data_in(serial_data_in), .word_valid(word_valid), .word_out(word_out),
  .word_ctrl(word_ctrl), .word_addr(word_addr), .word_data(word_data), .frame_active(frame_active),
  .frame_error(frame_error));
`default_nettype wire
